/* File: dma2d_map.svh */
`ifndef DMA2D_MAP_SVH
`define DMA2D_MAP_SVH

// x/y count-stride word layout: count in the upper half, stride in the lower
`define CNT_MSB 31
`define CNT_LSB 16
`define STRIDE_MSB 15
`define STRIDE_LSB 0
// channel control word field positions
`define TYPE_MSB 2
`define TYPE_LSB 0
`define INT_BIT 3
`define REQ_MODE_BIT 4
`define CHAIN_BIT 5
`define TWO_DIM_BIT 6
// reset values
`define CTRL_RESET 32'h0000_0000
`define ADDR_RESET 32'h0000_0000
`define COUNT_RESET 32'h0000_0000

`endif

/* File: dma2d_pkg.sv */
package dma2d_pkg;
   typedef struct packed {
      logic [31:0] address;
      logic [31:0] x_count_stride;
      logic [31:0] y_count_stride;
      logic [31:0] control;
   } tcb_t;

   typedef struct packed {
      logic valid;
      logic [31:0] address;
      logic last;
   } mem_req_t;

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_wait_req = 3'b001,
      st_xphase = 3'b010,
      st_yphase = 3'b011,
      st_drain = 3'b100,
      st_chain = 3'b101
   } seq_state_t;
endpackage

/* File: dma_far_side_model.sv */
module dma_far_side_model (
   // clock and reset
   input wire logic mclk, reset,
   // memory side
   input wire dma2d_pkg::mem_req_t mem_req,
   input wire logic pause, dest_internal,
   output logic mem_ready, write_landed, buffer_accepted,
   // chain loading
   input wire logic chain_load_req,
   input wire dma2d_pkg::tcb_t next_tcb,
   output logic chain_load_done,
   output dma2d_pkg::tcb_t chain_tcb
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] ph, lag;
   wire beat = mem_req.valid && mem_ready && !pause;
   // memory stalls one cycle in four
   assign mem_ready = ph[1:0] != 2'h3;
   // block is garbage except in the load cycle
   assign chain_tcb = chain_load_done ? next_tcb : ~next_tcb;
   always_ff @(posedge mclk) begin
      ph <= reset ? 3'h0 : ph + 3'h1;
      lag <= reset ? 3'h0 : (beat && mem_req.last) ? 3'h3 :
         (lag != 3'h0) ? lag - 3'h1 : lag;
      write_landed <= lag == 3'h1 && dest_internal;
      buffer_accepted <= lag == 3'h1 && !dest_internal;
      chain_load_done <= chain_load_req && !chain_load_done && ph[0];
   end
endmodule // dma_far_side_model

/* File: test_two_dim_dma_channel_sequencer.sv */
module test_two_dim_dma_channel_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, reset, tcb_load, pause, dest_internal, dma_request_input;
   logic mem_ready, write_landed, buffer_accepted, chain_load_req;
   logic chain_load_done, irq_mask_reg, irq_latch_clear, irq_latch_reg;
   logic dma_irq, hw_error_irq, dma_status_reg, herr;
   logic [31:0] current_address_reg, x_count_stride_reg, y_count_stride_reg;
   dma2d_pkg::tcb_t tcb_in, chain_tcb, next_tcb;
   dma2d_pkg::mem_req_t mem_req;
   logic [31:0] addrs[$];
   int err_count, n_tests, beats;
   two_dim_dma_channel_sequencer dut (.*);
   dma_far_side_model far (.*);
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      herr <= herr | hw_error_irq;
      if (mem_req.valid && mem_ready && !pause) begin
         beats <= beats + 1;
         addrs.push_back(mem_req.address);
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic load(logic [31:0] a, x, y, c);
      @(negedge mclk);
      beats = 0;
      addrs.delete();
      @(posedge mclk);
      tcb_in <= '{a, x, y, c};
      tcb_load <= 1'b1;
      @(posedge mclk);
      tcb_load <= 1'b0;
   endtask
   // bounded wait for the channel to go inactive
   task automatic idle(int n);
      repeat (2) @(posedge mclk);
      for (int i = 0; i < n && dma_status_reg !== 1'b0; i++)
         @(posedge mclk);
      if (dma_status_reg !== 1'b0) begin
         err_count++;
         wrap_up();
      end
   endtask
   task automatic fall();
      dma_request_input <= 1'b0;
      repeat (4) @(posedge mclk);
      dma_request_input <= 1'b1;
      repeat (10) @(posedge mclk);
   endtask
   initial begin
      reset = 1'b1;
      {tcb_load, pause, irq_latch_clear, herr, err_count, n_tests} = '0;
      {dest_internal, dma_request_input, irq_mask_reg} = 3'b111;
      tcb_in = '0;
      next_tcb = '{32'h600, 32'h0001_0001, 32'h0, 32'h09};
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      load(32'h100, 32'h0002_0006, 32'h0006_fffb, 32'h49);
      idle(200);
      chk("beats", 12, beats);
      foreach (addrs[k]) chk("addr", 32'h100 + k / 2 + 6 * (k % 2), addrs[k]);
      repeat (4) @(posedge mclk);
      chk("irq", 1, dma_irq);
      chk("x reg", 32'h0000_0006, x_count_stride_reg);
      chk("y reg", 32'h0001_fffb, y_count_stride_reg);
      $display("test 2d done");
      irq_latch_clear <= 1'b1;
      irq_mask_reg <= 1'b0;
      dest_internal <= 1'b0;
      @(posedge mclk);
      irq_latch_clear <= 1'b0;
      load(32'h200, 32'h0003_0004, 32'h0005_0001, 32'h09);
      idle(100);
      chk("beats", 3, beats);
      chk("addr", 32'h208, current_address_reg);
      chk("x reg", 32'h0000_0004, x_count_stride_reg);
      repeat (4) @(posedge mclk);
      chk("latch", 1, irq_latch_reg);
      chk("irq", 0, dma_irq);
      irq_latch_clear <= 1'b1;
      @(posedge mclk);
      irq_latch_clear <= 1'b0;
      load(32'h0, 32'h0, 32'h0, 32'h0);
      repeat (6) @(posedge mclk);
      chk("latch", 0, irq_latch_reg);
      chk("beats", 0, beats);
      $display("test 1d done");
      load(32'h300, 32'h0002_0001, 32'h0, 32'h11);
      repeat (10) @(posedge mclk);
      chk("beats", 0, beats);
      fall();
      chk("beats", 1, beats);
      pause <= 1'b1;
      fall();
      chk("beats", 1, beats);
      pause <= 1'b0;
      fall();
      chk("beats", 2, beats);
      idle(50);
      $display("test request done");
      load(32'h400, 32'h0001_0001, 32'h0, 32'h11);
      load(32'h500, 32'h0001_0001, 32'h0, 32'h11);
      repeat (2) @(posedge mclk);
      chk("hw error", 1, herr);
      load(32'h0, 32'h0, 32'h0, 32'h0);
      repeat (4) @(posedge mclk);
      chk("status", 0, dma_status_reg);
      $display("test error done");
      load(32'h500, 32'h0002_0001, 32'h0, 32'h29);
      idle(300);
      chk("beats", 3, beats);
      chk("addr", 32'h600, addrs[2]);
      $display("test chain done");
      wrap_up();
   end
endmodule // test_two_dim_dma_channel_sequencer

/* File: two_dim_dma_channel_sequencer.sv */
`include "dma2d_map.svh"

// Behaviour
// - first phase drives the current address out and starts a memory cycle.
// - the X stride is added to the address in the access cycle.
// - X count decrements per transfer; reaching zero enters second phase, no stride.
// - second phase restores X count from the hidden reload copy.
// - second phase adds the signed Y stride instead of the X stride.
// - Y count decrements; at zero the sequence ends until reloaded.
// - the first transfer happens before any address change, even with zero counts.
// - clearing the two-dimensional enable bit gives one-dimensional behaviour.
// - a cleared transfer type disables the channel and ends the sequence.
// - completion interrupt when enabled, X count reaches zero, last transfer done.
// - internal destination completes only after the last write lands.
// - external destination completes when last element enters fifo or buffer.
// - a software write of zero to a count never raises completion.
// - each channel has its own interrupt line, latched and masked.
// - this channel's interrupt priority is fixed, independent of bus rotation.
// - enabled, unchained, request mode: start on falling request input.
// - enabled, unchained, no request mode: start at once.
// - chaining on: chain-load after each block and start the next.
// - loading an active block into an active channel raises an error.
// - sequence ends when counts reach zero and no chained block follows.
// - pause suspends, clearing resumes; later falling request continues.
// - X register holds count in upper 16 bits, stride in lower 16.
// - Y stride is sign-extended before adding to the 32-bit address.

module two_dim_dma_channel_sequencer #(
   parameter int ADDR_W = 32
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // control block load (core or external write; chaining loads through the chain_tcb port)
   input wire logic tcb_load,
   input wire dma2d_pkg::tcb_t tcb_in,
   // pause bit of the dma control register
   input wire logic pause,
   // destination is internal memory when high
   input wire logic dest_internal,
   // external request pin, asynchronous
   input wire logic dma_request_input,
   // memory side
   output dma2d_pkg::mem_req_t mem_req,
   input wire logic mem_ready,
   input wire logic write_landed,
   input wire logic buffer_accepted,
   // chain loading
   output logic chain_load_req,
   input wire logic chain_load_done,
   input wire dma2d_pkg::tcb_t chain_tcb,
   // interrupt latch and mask
   input wire logic irq_mask_reg,
   input wire logic irq_latch_clear,
   output logic irq_latch_reg,
   output logic dma_irq,
   output logic hw_error_irq,
   // status
   output logic dma_status_reg,
   output logic [ADDR_W-1:0] current_address_reg,
   output logic [31:0] x_count_stride_reg,
   output logic [31:0] y_count_stride_reg
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   dma2d_pkg::seq_state_t state;
   dma2d_pkg::seq_state_t next_state;
   logic [31:0] channel_control_word;
   logic [15:0] x_count_reload_copy;
   logic req_sync1;
   logic req_sync2;
   logic req_prev;
   logic last_pending;
   logic complete_pending;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // both counts step down the same way; a zero count wraps on purpose
   function automatic logic [15:0] count_dec(input logic [15:0] c);
      count_dec = c - 16'h0001;
   endfunction

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   wire [2:0] transfer_type_field =
      channel_control_word[`TYPE_MSB:`TYPE_LSB];
   wire enabled = (transfer_type_field != 3'h0);
   wire irq_enable = channel_control_word[`INT_BIT];
   wire request_mode_enable = channel_control_word[`REQ_MODE_BIT];
   wire chain_enable = channel_control_word[`CHAIN_BIT];
   wire two_dim_enable = channel_control_word[`TWO_DIM_BIT];
   wire [15:0] x_count = x_count_stride_reg[`CNT_MSB:`CNT_LSB];
   wire [15:0] x_stride = x_count_stride_reg[`STRIDE_MSB:`STRIDE_LSB];
   wire [15:0] y_count = y_count_stride_reg[`CNT_MSB:`CNT_LSB];
   wire [15:0] y_stride = y_count_stride_reg[`STRIDE_MSB:`STRIDE_LSB];
   wire req_fall = req_prev & ~req_sync2;
   wire active = (state != dma2d_pkg::st_idle);
   wire load_tcb = tcb_load | (state == dma2d_pkg::st_chain &&
      chain_load_done);
   wire dma2d_pkg::tcb_t new_tcb = tcb_load ? tcb_in : chain_tcb;
   // zero count after the decrement; a zero load just wraps, so one
   // transfer always happens first
   wire [15:0] x_dec = count_dec(x_count);
   wire x_done = (x_dec == 16'h0000);
   wire [15:0] y_dec = count_dec(y_count);
   wire y_done = (y_dec == 16'h0000) || !two_dim_enable;
   // a beat needs the presented cycle, so memory and this block agree
   wire beat = (state == dma2d_pkg::st_xphase) && mem_req.valid &&
      !pause && mem_ready;
   // the cycle is offered only once the address register has settled:
   // one idle cycle after entry and after each beat, traded for never
   // presenting a stale address after an x or y step
   wire next_valid = (state == dma2d_pkg::st_xphase) &&
      (next_state == dma2d_pkg::st_xphase) && !beat && !pause &&
      !load_tcb;
   wire may_go = !request_mode_enable || req_fall;
   wire landed = dest_internal ? write_landed : buffer_accepted;
   wire last_beat = beat && x_done && y_done;

   function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a,
                                              input logic [15:0] s);
      step = a + {{(ADDR_W-16){s[15]}}, s};
   endfunction

   // ------------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         dma2d_pkg::st_idle: begin
            next_state = dma2d_pkg::st_idle;
         end
         dma2d_pkg::st_wait_req: begin
            if (!pause && may_go) begin
               next_state = dma2d_pkg::st_xphase;
            end
         end
         dma2d_pkg::st_xphase: begin
            if (beat) begin
               if (x_done && y_done) begin
                  next_state = dma2d_pkg::st_drain;
               end else if (x_done) begin
                  next_state = dma2d_pkg::st_yphase;
               end else if (request_mode_enable) begin
                  next_state = dma2d_pkg::st_wait_req;
               end
            end
         end
         dma2d_pkg::st_yphase: begin
            if (!pause) begin
               next_state = request_mode_enable ?
                  dma2d_pkg::st_wait_req : dma2d_pkg::st_xphase;
            end
         end
         dma2d_pkg::st_drain: begin
            if (landed) begin
               next_state = chain_enable ? dma2d_pkg::st_chain :
                  dma2d_pkg::st_idle;
            end
         end
         dma2d_pkg::st_chain: begin
            next_state = dma2d_pkg::st_chain;
         end
         default: begin
            next_state = dma2d_pkg::st_idle;
         end
      endcase
      if (load_tcb) begin
         next_state = dma2d_pkg::st_wait_req;
      end
      if (!enabled && !load_tcb) begin
         next_state = dma2d_pkg::st_idle;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= dma2d_pkg::st_idle;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------------
   // control block registers
   // ------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         channel_control_word <= `CTRL_RESET;
         current_address_reg <= ADDR_W'(`ADDR_RESET);
         x_count_stride_reg <= `COUNT_RESET;
         y_count_stride_reg <= `COUNT_RESET;
         x_count_reload_copy <= 16'h0000;
      end else if (load_tcb) begin
         channel_control_word <= new_tcb.control;
         current_address_reg <= new_tcb.address[ADDR_W-1:0];
         x_count_stride_reg <= new_tcb.x_count_stride;
         y_count_stride_reg <= new_tcb.y_count_stride;
         x_count_reload_copy <=
            new_tcb.x_count_stride[`CNT_MSB:`CNT_LSB];
      end else if (beat) begin
         x_count_stride_reg[`CNT_MSB:`CNT_LSB] <= x_dec;
         if (!x_done) begin
            current_address_reg <= step(current_address_reg,
               x_stride);
         end
      end else if (state == dma2d_pkg::st_yphase && !pause) begin
         x_count_stride_reg[`CNT_MSB:`CNT_LSB] <=
            x_count_reload_copy;
         current_address_reg <= step(current_address_reg,
            y_stride);
         y_count_stride_reg[`CNT_MSB:`CNT_LSB] <= y_dec;
      end
   end

   // ------------------------------------------------------------------
   // request synchroniser and memory cycle
   // ------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         req_sync1 <= 1'b1;
         req_sync2 <= 1'b1;
         req_prev <= 1'b1;
      end else begin
         req_sync1 <= dma_request_input;
         req_sync2 <= req_sync1;
         req_prev <= req_sync2;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         mem_req <= '0;
      end else begin
         // address held until memory accepts the cycle
         mem_req.valid <= next_valid;
         mem_req.address <= current_address_reg;
         mem_req.last <= x_done && y_done;
      end
   end

   // ------------------------------------------------------------------
   // completion, error and interrupt latch
   // ------------------------------------------------------------------
   // the completion event comes only from a real last beat; a zero write
   // loads registers but never passes through st_drain
   always_ff @(posedge mclk) begin
      if (reset) begin
         last_pending <= 1'b0;
         complete_pending <= 1'b0;
         irq_latch_reg <= 1'b0;
         dma_irq <= 1'b0;
         hw_error_irq <= 1'b0;
         chain_load_req <= 1'b0;
         dma_status_reg <= 1'b0;
      end else begin
         last_pending <= last_beat ? 1'b1 :
            ((landed || !enabled) ? 1'b0 : last_pending);
         complete_pending <= (state == dma2d_pkg::st_drain) && landed &&
            irq_enable && last_pending;
         // set wins over clear; one line per block gives fixed priority
         irq_latch_reg <= complete_pending |
            (irq_latch_reg & ~irq_latch_clear);
         dma_irq <= irq_latch_reg & irq_mask_reg;
         hw_error_irq <= tcb_load && active &&
            (tcb_in.control[`TYPE_MSB:`TYPE_LSB] != 3'h0);
         chain_load_req <= (next_state == dma2d_pkg::st_chain);
         // polling is only meaningful without chaining
         dma_status_reg <= (next_state != dma2d_pkg::st_idle);
      end
   end

endmodule // two_dim_dma_channel_sequencer

/* File: two_dim_dma_channel_sequencer_asserts.sv */
module dma2d_checker #(parameter int ADDR_W = 32) (
   // clock and reset
   input wire logic mclk, reset,
   // block load and pause
   input wire logic tcb_load, pause,
   input wire dma2d_pkg::tcb_t tcb_in,
   // memory side
   input wire dma2d_pkg::mem_req_t mem_req,
   input wire logic mem_ready, write_landed, buffer_accepted,
   // interrupts and status
   input wire logic irq_mask_reg, irq_latch_reg, dma_irq,
   input wire logic hw_error_irq, dma_status_reg,
   input wire logic [ADDR_W-1:0] current_address_reg,
   input wire logic [31:0] x_count_stride_reg, y_count_stride_reg
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] xrel;
   logic two_dim;
   wire beat = mem_req.valid && mem_ready && !pause;
   wire [15:0] xc = x_count_stride_reg[31:16];
   wire [15:0] yc = y_count_stride_reg[31:16];
   wire [15:0] ys = y_count_stride_reg[15:0];
   wire [31:0] xs = {16'h0, x_count_stride_reg[15:0]};
   wire landed = write_landed || buffer_accepted;
   // chained blocks are not tracked: row checks cover core loads only
   always_ff @(posedge mclk)
      if (tcb_load) begin
         xrel <= tcb_in.x_count_stride[31:16];
         two_dim <= tcb_in.control[6];
      end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence row_end;
      beat && xc == 16'h1 && two_dim && yc != 16'h1;
   endsequence
   a_valid_holds: assert property (
      mem_req.valid && !mem_ready && !tcb_load |=> mem_req.valid
      && $stable(mem_req.address)) else $error("request dropped");
   a_x_stride_add: assert property (
      beat && xc != 16'h1 && !tcb_load |=> current_address_reg
      == $past(current_address_reg) + xs) else $error("x step");
   a_zero_no_step: assert property (
      beat && xc == 16'h1 |=> $stable(current_address_reg))
      else $error("stride at row end");
   a_x_count_dec: assert property (
      beat && !tcb_load |=> xc == $past(xc) - 16'h1) else $error("x count");
   a_row_reload: assert property (
      row_end |=> ##1 xc == xrel && yc == $past(yc) - 16'h1 &&
      current_address_reg == $past(current_address_reg) + {{16{ys[15]}}, ys})
      else $error("row step");
   a_irq_gate: assert property (
      dma_irq == $past(irq_latch_reg && irq_mask_reg)) else $error("irq gate");
   a_hw_error: assert property (
      hw_error_irq == $past(tcb_load && dma_status_reg &&
      tcb_in.control[2:0] != 3'h0)) else $error("hw error");
   a_irq_cause: assert property (
      $rose(irq_latch_reg) |-> $past(landed) || $past(landed, 2))
      else $error("irq without completion");
   a_type_zero: assert property (
      tcb_load && tcb_in.control[2:0] == 3'h0 |-> ##[1:2] !dma_status_reg)
      else $error("disable ignored");
endmodule // dma2d_checker

bind two_dim_dma_channel_sequencer dma2d_checker #(.ADDR_W(ADDR_W)) chk_i (.*);
